/* tps_pkg.sv */
package tps_pkg;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned TICK_US = 50;  // Prescaled tick period in us
  localparam int unsigned TICK_CYC = CLK_HZ / 1_000_000 * TICK_US;
  localparam int unsigned TICKS_PER_MS = 1000 / TICK_US;
  // Debounce times in ms
  localparam int unsigned DEB_MS_0 = 100;
  localparam int unsigned DEB_MS_1 = 50;
  localparam int unsigned DEB_MS_2 = 25;
  // Inter-position delays in tenths of a ms
  localparam int unsigned DLY_DMS_0 = 500;
  localparam int unsigned DLY_DMS_1 = 250;
  localparam int unsigned DLY_DMS_2 = 125;
  localparam int unsigned DLY_DMS_3 = 15;
  // Termination periods in ms
  localparam int unsigned TERM_MS_1 = 50;
  localparam int unsigned TERM_MS_2 = 100;
  localparam int unsigned TERM_MS_3 = 200;

  // ------------------------------------------------------------
  // Register map (word byte addresses)
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CFG = 8'h04;
  localparam logic [7:0] ADDR_POS = 8'h08;
  localparam logic [7:0] ADDR_ENA = 8'h0C;
  localparam logic [7:0] ADDR_FAULT = 8'h10;
  localparam logic [7:0] ADDR_VSEL = 8'h14;
  localparam logic [7:0] ADDR_STAT = 8'h18;
  localparam logic [7:0] ADDR_THR = 8'h1C;

  // CTRL bits (write one to act; self clearing)
  localparam int unsigned CTRL_ON = 0;
  localparam int unsigned CTRL_OFF = 1;
  localparam int unsigned CTRL_FORCE = 2;

  // Reset values
  localparam logic [31:0] CFG_RST = 32'h0000_0000;
  localparam logic [31:0] POS_RST = 32'h0000_0024;
  localparam logic [2:0] ENA_RST = 3'h7;
  localparam logic [31:0] FAULT_RST = 32'h0000_0000;
  localparam logic [31:0] THR_RST = 32'h0000_0000;
  localparam logic [31:0] BUS_ERR_DATA = 32'h0000_0000;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {SRC_NONE, SRC_LEVEL, SRC_EDGE, SRC_BUTTON} tps_src_t;

  typedef struct packed {
    logic [10:0] rsvd;
    logic [2:0] glitch_ticks;   // 20:18 fault filter length in ticks
    logic [2:0] ena_from_pin;   // 17:15 per-channel enable source
    logic [1:0] fault_resp_rst; // 14 health out, 13 unused spare
    logic fault_resp_off;       // 12 power-off sequence on fault
    logic fault_resp_force;     // 11 force shutdown on fault
    logic [1:0] term_sel;       // 10:9 0 off, 1 50, 2 100, 3 200 ms
    logic [1:0] deb_sel;        // 8:7 0 100,1 50,2 25 ms,3 none
    logic manual;               // 6
    logic auto_start;           // 5
    logic [2:0] rsvd2;          // 4:2
    tps_src_t src;              // 1:0
  } tps_cfg_t;

  typedef struct packed {
    logic [19:0] rsvd;
    logic [1:0] dly2;     // 11:10 delay code of position 2, loaded but never waited on
    logic [1:0] dly1;     // 9:8
    logic [1:0] dly0;     // 7:6
    logic [1:0] pos2;     // 5:4 position of channel 2
    logic [1:0] pos1;     // 3:2
    logic [1:0] pos0;     // 1:0
  } tps_pos_t;

  typedef enum logic [2:0] {ST_OFF, ST_UP_EN, ST_UP_DLY, ST_ON, ST_DN_WAIT, ST_DN_DLY}
    tps_state_t;

endpackage

/* tps_sequencer.sv */
// The register addresses and the Wishbone slave port are this design's own decisions.
module tps_sequencer
  import tps_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Pins and analog comparators
  input wire logic power_request_pin_i,
  input wire logic [2:0] ch_above_ref_i,   // Output above sequencing reference
  input wire logic [2:0] ch_off_i,         // Output discharged
  input wire logic [2:0] ch_uv_i,
  input wire logic [2:0] ch_ov_i,
  input wire logic [1:0] batt_uv_i,        // Below threshold A / B
  input wire logic [2:0] ch_at_set_i,      // Output settled at selected point
  output logic [2:0] ch_en_o,
  output logic [2:0] ch_soft_start_o,
  output logic [5:0] ch_uvov_thr_o,        // Two bits per channel
  output logic [5:0] batt_thr_o,           // Two 3-bit codes
  output logic [8:0] ch_vsel_o,            // Three bits per channel
  output logic health_indicator_out_o,
  output logic system_reset_out_n_o
);

  // ----------------------------------------------------------
  // Functions
  // ----------------------------------------------------------
  // Channel mask for one sequence position
  function automatic logic [2:0] pos_mask(input tps_pos_t p, input logic [1:0] n);
    pos_mask = {p.pos2 == n, p.pos1 == n, p.pos0 == n};
  endfunction

  // Delay code of a position, in ticks
  function automatic logic [15:0] dly_ticks(input logic [1:0] c);
    case (c)
      2'd0: dly_ticks = 16'(DLY_DMS_0 * TICKS_PER_MS / 10);
      2'd1: dly_ticks = 16'(DLY_DMS_1 * TICKS_PER_MS / 10);
      2'd2: dly_ticks = 16'(DLY_DMS_2 * TICKS_PER_MS / 10);
      default: dly_ticks = 16'(DLY_DMS_3 * TICKS_PER_MS / 10);
    endcase
  endfunction

  // ----------------------------------------------------------
  // Registers
  // ----------------------------------------------------------
  tps_cfg_t cfg_ff;
  tps_pos_t pos_cfg_ff;
  logic [2:0] ena_ff;
  logic [2:0] ena_dflt_ff;
  logic [31:0] fault_ff;
  logic [8:0] vsel_ff;
  logic [11:0] thr_ff;
  logic cmd_on_ff;
  logic cmd_off_ff;
  logic cmd_force_ff;
  logic dvs_done_ff;
  logic ack_ff;
  logic [31:0] rdat_ff;
  tps_state_t state_ff;
  logic [1:0] pos_ff;
  logic [2:0] state_code;
  logic [31:0] wmask;
  logic wr;

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdat_ff;
  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !ack_ff;
  assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  // Bus answer one cycle after request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= wb_cyc_i && wb_stb_i && !ack_ff;
    end
  end

  // Read mux
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdat_ff <= BUS_ERR_DATA;
    end else if (wb_cyc_i && wb_stb_i && !wb_we_i && !ack_ff) begin
      if (wb_adr_i == ADDR_CFG) begin
        rdat_ff <= cfg_ff;
      end else if (wb_adr_i == ADDR_POS) begin
        rdat_ff <= pos_cfg_ff;
      end else if (wb_adr_i == ADDR_ENA) begin
        rdat_ff <= {25'h0, ena_dflt_ff, 1'b0, ena_ff};
      end else if (wb_adr_i == ADDR_FAULT) begin
        rdat_ff <= fault_ff;
      end else if (wb_adr_i == ADDR_VSEL) begin
        rdat_ff <= {23'h0, vsel_ff};
      end else if (wb_adr_i == ADDR_STAT) begin
        rdat_ff <= {22'h0, dvs_done_ff, state_code, ch_en_o, 1'b0, pos_ff};
      end else if (wb_adr_i == ADDR_THR) begin
        rdat_ff <= {20'h0, thr_ff};
      end else begin
        rdat_ff <= BUS_ERR_DATA;
      end
    end
  end

  // Configuration registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_ff <= CFG_RST;
      pos_cfg_ff <= POS_RST;
      thr_ff <= THR_RST[11:0];
      ena_dflt_ff <= ENA_RST;
    end else if (wr) begin
      if (wb_adr_i == ADDR_CFG) begin
        cfg_ff <= (cfg_ff & ~wmask) | (wb_dat_i & wmask);
      end else if (wb_adr_i == ADDR_POS) begin
        pos_cfg_ff <= (pos_cfg_ff & ~wmask) | (wb_dat_i & wmask);
      end else if (wb_adr_i == ADDR_THR) begin
        thr_ff <= 12'((thr_ff & wmask[11:0]) ^ thr_ff | (wb_dat_i[11:0] & wmask[11:0]));
      end else if (wb_adr_i == ADDR_ENA && wb_sel_i[0]) begin
        ena_dflt_ff <= wb_dat_i[6:4];
      end
    end
  end

  // Threshold codes: 2-bit UV/OV percent per channel, battery 3-bit codes
  assign ch_uvov_thr_o = thr_ff[5:0];
  assign batt_thr_o = thr_ff[11:6];

  // Enable register, loads default after reset
  logic ena_loaded_ff;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ena_ff <= 3'h0;
      ena_loaded_ff <= 1'b0;
    end else if (!ena_loaded_ff) begin
      ena_ff <= ena_dflt_ff;
      ena_loaded_ff <= 1'b1;
    end else if (wr && wb_adr_i == ADDR_ENA && wb_sel_i[0]) begin
      ena_ff <= wb_dat_i[2:0];
    end
  end

  // Command strobes and voltage select
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmd_on_ff <= 1'b0;
      cmd_off_ff <= 1'b0;
      cmd_force_ff <= 1'b0;
      vsel_ff <= 9'h000;
    end else begin
      cmd_on_ff <= wr && wb_adr_i == ADDR_CTRL && wb_sel_i[0] && wb_dat_i[CTRL_ON];
      cmd_off_ff <= wr && wb_adr_i == ADDR_CTRL && wb_sel_i[0] && wb_dat_i[CTRL_OFF];
      cmd_force_ff <= wr && wb_adr_i == ADDR_CTRL && wb_sel_i[0] && wb_dat_i[CTRL_FORCE];
      if (wr && wb_adr_i == ADDR_VSEL) begin
        vsel_ff <= 9'((vsel_ff & ~wmask[8:0]) | (wb_dat_i[8:0] & wmask[8:0]));
      end
    end
  end
  assign ch_vsel_o = vsel_ff;

  // ----------------------------------------------------------
  // Tick prescaler
  // ----------------------------------------------------------
  logic [10:0] pre_ff;
  logic tick;
  assign tick = pre_ff == 11'(TICK_CYC - 1);
  always_ff @(posedge clk_i) begin
    if (rst_i || tick) begin
      pre_ff <= 11'h000;
    end else begin
      pre_ff <= pre_ff + 11'h001;
    end
  end

  // ----------------------------------------------------------
  // Request pin: synchroniser and debounce
  // ----------------------------------------------------------
  logic req_s1_ff;
  logic req_s2_ff;
  logic req_db_ff;
  logic req_db_prev_ff;
  logic [11:0] deb_cnt_ff;
  logic [11:0] deb_lim;
  always_comb begin
    case (cfg_ff.deb_sel)
      2'd0: deb_lim = 12'(DEB_MS_0 * TICKS_PER_MS);
      2'd1: deb_lim = 12'(DEB_MS_1 * TICKS_PER_MS);
      default: deb_lim = 12'(DEB_MS_2 * TICKS_PER_MS);
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      req_s1_ff <= 1'b0;
      req_s2_ff <= 1'b0;
    end else begin
      req_s1_ff <= power_request_pin_i;
      req_s2_ff <= req_s1_ff;
    end
  end

  // Debounced level changes only after a stable period unless deb_sel is 3
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      req_db_ff <= 1'b0;
      deb_cnt_ff <= 12'h000;
    end else if (cfg_ff.deb_sel == 2'd3) begin
      req_db_ff <= req_s2_ff;
      deb_cnt_ff <= 12'h000;
    end else if (req_s2_ff == req_db_ff) begin
      deb_cnt_ff <= 12'h000;
    end else if (tick) begin
      if (deb_cnt_ff >= deb_lim) begin
        req_db_ff <= req_s2_ff;
        deb_cnt_ff <= 12'h000;
      end else begin
        deb_cnt_ff <= deb_cnt_ff + 12'h001;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      req_db_prev_ff <= 1'b0;
    end else begin
      req_db_prev_ff <= req_db_ff;
    end
  end

  logic req_rise;
  logic req_fall;
  assign req_rise = req_db_ff && !req_db_prev_ff;
  assign req_fall = !req_db_ff && req_db_prev_ff;

  // Effective channel enables
  logic [2:0] ch_ena;
  assign ch_ena = (cfg_ff.ena_from_pin & {3{req_db_ff}}) | (~cfg_ff.ena_from_pin & ena_ff);

  // ----------------------------------------------------------
  // Fault filter
  // ----------------------------------------------------------
  logic [7:0] flt_s1_ff;
  logic [7:0] flt_s2_ff;
  logic [2:0] flt_cnt_ff;
  logic fault_ff_q;
  logic fault_rise;
  logic fault_q_prev_ff;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flt_s1_ff <= 8'h00;
      flt_s2_ff <= 8'h00;
    end else begin
      flt_s1_ff <= {batt_uv_i, ch_ov_i, ch_uv_i};
      flt_s2_ff <= flt_s1_ff;
    end
  end

  // Fault must persist for glitch_ticks ticks
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flt_cnt_ff <= 3'h0;
      fault_ff_q <= 1'b0;
    end else if (flt_s2_ff == 8'h00) begin
      flt_cnt_ff <= 3'h0;
      fault_ff_q <= 1'b0;
    end else if (flt_cnt_ff >= cfg_ff.glitch_ticks) begin
      fault_ff_q <= 1'b1;
    end else if (tick) begin
      flt_cnt_ff <= flt_cnt_ff + 3'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fault_q_prev_ff <= 1'b0;
    end else begin
      fault_q_prev_ff <= fault_ff_q;
    end
  end
  assign fault_rise = fault_ff_q && !fault_q_prev_ff;

  // Sticky fault record; write one to clear, set wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fault_ff <= FAULT_RST;
    end else begin
      fault_ff <= (fault_ff & ~((wr && wb_adr_i == ADDR_FAULT) ? (wb_dat_i & wmask) : 32'h0))
                  | {24'h0, flt_s2_ff & {8{fault_ff_q}}};
    end
  end

  // ----------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------
  logic [2:0] on_ff;
  logic [15:0] dly_ff;
  logic [12:0] term_ff;
  logic started_ff;
  logic [12:0] term_lim;
  logic [2:0] cur_mask;
  logic fault_act;
  logic start_req;
  logic stop_req;
  logic force_sd;
  assign state_code = 3'(state_ff);
  assign cur_mask = pos_mask(pos_cfg_ff, pos_ff);
  assign fault_act = fault_ff_q && !cfg_ff.manual;

  always_comb begin
    case (cfg_ff.term_sel)
      2'd1: term_lim = 13'(TERM_MS_1 * TICKS_PER_MS);
      2'd2: term_lim = 13'(TERM_MS_2 * TICKS_PER_MS);
      default: term_lim = 13'(TERM_MS_3 * TICKS_PER_MS);
    endcase
  end

  // Start and stop sources
  always_comb begin
    start_req = cmd_on_ff || (cfg_ff.auto_start && !started_ff);
    stop_req = cmd_off_ff || (fault_rise && cfg_ff.fault_resp_off && !cfg_ff.manual);
    case (cfg_ff.src)
      SRC_LEVEL: begin
        start_req = start_req || req_db_ff;
        stop_req = stop_req || req_fall;
      end
      SRC_EDGE: start_req = start_req || req_rise;
      SRC_BUTTON: begin
        start_req = start_req || req_rise;
        stop_req = stop_req || req_fall;
      end
      default: ;
    endcase
  end

  logic term_hit;
  assign term_hit = cfg_ff.term_sel != 2'd0 && term_ff >= term_lim;
  assign force_sd = cmd_force_ff || (fault_act && cfg_ff.fault_resp_force)
                    || (fault_ff_q && (cfg_ff.fault_resp_force | cfg_ff.fault_resp_off) == 1'b0
                        && !cfg_ff.manual && 1'b0)
                    || term_hit;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      started_ff <= 1'b0;
    end else if (start_req) begin
      started_ff <= 1'b1;
    end
  end

  // Termination timer, counts only in ST_UP_EN and ST_DN_WAIT
  always_ff @(posedge clk_i) begin
    if (rst_i || state_ff == ST_OFF || state_ff == ST_ON || state_ff == ST_UP_DLY
        || state_ff == ST_DN_DLY || cfg_ff.manual) begin
      term_ff <= 13'h0000;
    end else if (tick && !term_hit) begin
      term_ff <= term_ff + 13'h0001;
    end
  end

  // Main sequence state machine
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= ST_OFF;
      pos_ff <= 2'd0;
      on_ff <= 3'h0;
      dly_ff <= 16'h0000;
    end else if (cfg_ff.manual) begin
      on_ff <= ch_ena;
      state_ff <= ST_OFF;
    end else if (force_sd) begin
      on_ff <= 3'h0;
      state_ff <= ST_OFF;
      pos_ff <= 2'd0;
    end else begin
      case (state_ff)
        ST_OFF: begin
          if (start_req) begin
            pos_ff <= 2'd0;
            state_ff <= ST_UP_EN;
          end
        end
        ST_UP_EN: begin
          if (stop_req) begin
            pos_ff <= 2'd2;
            state_ff <= ST_DN_WAIT;
            on_ff <= on_ff & ~pos_mask(pos_cfg_ff, 2'd2);
          end else if ((cur_mask & ch_ena) == 3'h0) begin
            dly_ff <= 16'h0000;
            state_ff <= (pos_ff == 2'd2) ? ST_ON : ST_UP_EN;
            pos_ff <= pos_ff + 2'd1;
          end else begin
            on_ff <= on_ff | (cur_mask & ch_ena);
            if ((cur_mask & ch_ena & ~ch_above_ref_i) == 3'h0) begin
              dly_ff <= dly_ticks(pos_ff == 2'd0 ? pos_cfg_ff.dly0 : pos_ff == 2'd1
                                  ? pos_cfg_ff.dly1 : pos_cfg_ff.dly2);
              state_ff <= (pos_ff == 2'd2) ? ST_ON : ST_UP_DLY;
            end
          end
        end
        ST_UP_DLY: begin
          if (stop_req) begin
            pos_ff <= 2'd2;
            state_ff <= ST_DN_WAIT;
            on_ff <= on_ff & ~pos_mask(pos_cfg_ff, 2'd2);
          end else if (dly_ff == 16'h0000) begin
            pos_ff <= pos_ff + 2'd1;
            state_ff <= ST_UP_EN;
          end else if (tick) begin
            dly_ff <= dly_ff - 16'h0001;
          end
        end
        ST_ON: begin
          if (stop_req) begin
            pos_ff <= 2'd2;
            on_ff <= on_ff & ~pos_mask(pos_cfg_ff, 2'd2);
            state_ff <= ST_DN_WAIT;
          end
        end
        ST_DN_WAIT: begin
          if ((cur_mask & ~ch_off_i) == 3'h0) begin
            if (pos_ff == 2'd0) begin
              state_ff <= ST_OFF;
            end else begin
              dly_ff <= dly_ticks(pos_ff == 2'd1 ? pos_cfg_ff.dly0 : pos_cfg_ff.dly1);
              state_ff <= ST_DN_DLY;
            end
          end
        end
        ST_DN_DLY: begin
          if (dly_ff == 16'h0000) begin
            pos_ff <= pos_ff - 2'd1;
            on_ff <= on_ff & ~pos_mask(pos_cfg_ff, pos_ff - 2'd1);
            state_ff <= ST_DN_WAIT;
          end else if (tick) begin
            dly_ff <= dly_ff - 16'h0001;
          end
        end
        default: state_ff <= ST_OFF;
      endcase
    end
  end

  assign ch_en_o = on_ff;
  // Soft start everywhere but the power-off sequence states, which turn off hard
  assign ch_soft_start_o = (state_ff == ST_DN_WAIT || state_ff == ST_DN_DLY) ? 3'h0 : 3'h7;

  // ----------------------------------------------------------
  // Health output and dynamic voltage status
  // ----------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      health_indicator_out_o <= 1'b0;
      system_reset_out_n_o <= 1'b0;
    end else begin
      health_indicator_out_o <= state_ff == ST_ON
                                && !(fault_ff_q && cfg_ff.fault_resp_rst[1]);
      system_reset_out_n_o <= state_ff == ST_ON
                              && !(fault_ff_q && cfg_ff.fault_resp_rst[1]);
    end
  end

  // Done flag sets when all settled, else clears on a new selection write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dvs_done_ff <= 1'b0;
    end else if (&ch_at_set_i) begin
      dvs_done_ff <= 1'b1;
    end else if (wr && wb_adr_i == ADDR_VSEL) begin
      dvs_done_ff <= 1'b0;
    end
  end

endmodule // tps_sequencer

/* tps_buck_model.sv */
module tps_buck_model #(
  parameter int RAMP = 40
) (
  input wire logic clk_i,
  input wire logic [2:0] ch_en_i,
  output logic [2:0] ch_above_ref_o,
  output logic [2:0] ch_off_o,
  output logic [2:0] ch_at_set_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int lvl[3] = '{0, 0, 0};
  // Output level ramps up while enabled, decays while disabled
  always @(posedge clk_i) begin
    for (int i = 0; i < 3; i++) begin
      if (ch_en_i[i]) lvl[i] <= (lvl[i] < RAMP) ? lvl[i] + 1 : RAMP;
      else lvl[i] <= (lvl[i] > 0) ? lvl[i] - 1 : 0;
    end
  end
  // Comparator levels seen by the sequencer
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      ch_above_ref_o[i] = (lvl[i] >= RAMP);
      ch_off_o[i] = (lvl[i] == 0);
      ch_at_set_o[i] = (lvl[i] >= RAMP);
    end
  end
endmodule // tps_buck_model

/* tps_sequencer_chk.sv */
module tps_sequencer_chk
  import tps_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o,
  input wire logic [2:0] ch_uv_i,
  input wire logic [2:0] ch_en_o,
  input wire logic [5:0] ch_uvov_thr_o,
  input wire logic [5:0] batt_thr_o,
  input wire logic [8:0] ch_vsel_o,
  input wire logic health_indicator_out_o,
  input wire logic system_reset_out_n_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ----------------------------------------
  // Shadow copies of written registers
  // ----------------------------------------
  wire wr = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
  tps_cfg_t cfg_ff;
  logic [2:0] ena_ff;
  logic [11:0] thr_ff;
  logic [8:0] vsel_ff;
  // Configuration shadow
  always_ff @(posedge clk_i) begin
    if (rst_i) cfg_ff <= tps_cfg_t'(CFG_RST);
    else if (wr && wb_adr_i == ADDR_CFG) cfg_ff <= tps_cfg_t'(wb_dat_i);
  end
  // Enable, threshold and set point shadows
  always_ff @(posedge clk_i) begin
    if (wr && wb_adr_i == ADDR_ENA) ena_ff <= wb_dat_i[2:0];
    if (wr && wb_adr_i == ADDR_THR) thr_ff <= wb_dat_i[11:0];
    if (wr && wb_adr_i == ADDR_VSEL) vsel_ff <= wb_dat_i[8:0];
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held past one cycle");
  chk_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack one cycle after request");
  chk_reset_quiet: assert property (disable iff (1'b0) rst_i
    |=> ch_en_o == 3'h0 && !health_indicator_out_o) else $error("outputs live in reset");
  chk_health_same: assert property (system_reset_out_n_o == health_indicator_out_o)
    else $error("health and reset outputs differ");
  chk_force_cmd: assert property (wr && wb_adr_i == ADDR_CTRL && wb_dat_i[CTRL_FORCE]
    |-> ##[1:4] ch_en_o == 3'h0) else $error("force command left a channel on");
  // Cycles an unfiltered output fault has stood with a channel still on
  logic [10:0] flt_wait_ff;
  always_ff @(posedge clk_i) begin
    if (rst_i || cfg_ff.manual || !cfg_ff.fault_resp_force || cfg_ff.glitch_ticks != 3'h0
        || !(|ch_uv_i) || ch_en_o == 3'h0) flt_wait_ff <= 11'h000;
    else flt_wait_ff <= flt_wait_ff + 11'h001;
  end
  chk_fault_force: assert property (flt_wait_ff < 11'h514)
    else $error("output fault did not shut down");
  chk_manual_follow: assert property (wr && wb_adr_i == ADDR_ENA && cfg_ff.manual
    && cfg_ff.ena_from_pin == 3'h0 |=> ##[0:5] ch_en_o == ena_ff)
    else $error("manual enable not followed");
  chk_thr_drive: assert property (wr && wb_adr_i == ADDR_THR
    |=> ##[0:2] {batt_thr_o, ch_uvov_thr_o} == thr_ff) else $error("thresholds not driven");
  chk_vsel_drive: assert property (wr && wb_adr_i == ADDR_VSEL
    |=> ##[0:2] ch_vsel_o == vsel_ff) else $error("set point select not driven");
  cover property (wr && wb_adr_i == ADDR_CTRL && wb_dat_i[CTRL_FORCE]);
  cover property ($fell(ch_en_o[0]));
  cover property (cfg_ff.manual && (|ch_uv_i) && (|ch_en_o));
endmodule // tps_sequencer_chk

bind tps_sequencer tps_sequencer_chk tps_sequencer_chk_inst (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .ch_uv_i(ch_uv_i), .ch_en_o(ch_en_o),
  .ch_uvov_thr_o(ch_uvov_thr_o), .batt_thr_o(batt_thr_o), .ch_vsel_o(ch_vsel_o),
  .health_indicator_out_o(health_indicator_out_o),
  .system_reset_out_n_o(system_reset_out_n_o));

/* tps_sequencer_tb.sv */
module tps_sequencer_tb
  import tps_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0000_0000, q, wdo;
  logic [2:0] uv = 3'h0, ov = 3'h0, en_x, ref_w, off_w, set_w, ch_en_o, ss;
  logic [1:0] buv = 2'h0;
  logic [5:0] uthr, bthr;
  logic [8:0] vsel;
  logic ack, pin = 1'b0;
  int bad_count = 0, n_compared = 0, seed = 41, t, d;
  always #20 clk_i = ~clk_i;
  tps_sequencer tps_sequencer_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat),
    .wb_dat_o(wdo), .wb_ack_o(ack), .power_request_pin_i(pin), .ch_above_ref_i(ref_w),
    .ch_off_i(off_w), .ch_uv_i(uv), .ch_ov_i(ov), .batt_uv_i(buv), .ch_at_set_i(set_w),
    .ch_en_o(ch_en_o), .ch_soft_start_o(ss), .ch_uvov_thr_o(uthr), .batt_thr_o(bthr),
    .ch_vsel_o(vsel), .health_indicator_out_o(), .system_reset_out_n_o());
  tps_buck_model #(.RAMP(40)) tps_buck_model_inst (.clk_i(clk_i), .ch_en_i(ch_en_o),
    .ch_above_ref_o(ref_w), .ch_off_o(off_w), .ch_at_set_o(set_w));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic int dly_cyc(input logic [1:0] c);
    int dms[4] = '{DLY_DMS_0, DLY_DMS_1, DLY_DMS_2, DLY_DMS_3};
    return dms[c] * TICKS_PER_MS * TICK_CYC / 10;
  endfunction
  task automatic test_done();
    if (bad_count == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Classic cycle, held until ack, then one idle cycle
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] v);
    int n;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= v;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = wdo;
    cyc <= 1'b0;
    stb <= 1'b0;
    chk("bus ack", 1'b1, ack);
    @(posedge clk_i);
    if (n >= 50) test_done();
  endtask
  // Bounded wait for an enable pattern; t counts cycles
  task automatic wait_en(input logic [2:0] e, input int lim);
    t = 0;
    while (ch_en_o !== e && t < lim) begin
      @(posedge clk_i);
      t++;
    end
    chk("ch_en", e, ch_en_o);
    if (ch_en_o !== e) test_done();
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [31:0] r;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    d = dly_cyc(2'h3);
    wb(0, ADDR_CFG, 0);
    chk("cfg", CFG_RST, q);
    wb(0, ADDR_POS, 0);
    chk("pos", POS_RST, q);
    wb(0, ADDR_ENA, 0);
    chk("ena", {25'h0, ENA_RST, 1'b0, ENA_RST}, q);
    wb(0, 8'hFC, 0);
    chk("unmapped", BUS_ERR_DATA, q);
    r = $random(seed);
    wb(1, ADDR_THR, r);
    chk("thr", r[11:0], {bthr, uthr});
    wb(1, ADDR_VSEL, 32'h0000_01A6);
    chk("vsel", 32'h0000_01A6, vsel);
    wb(1, ADDR_CFG, 32'h0000_0840);
    repeat (4) begin
      r = $random(seed);
      wb(1, ADDR_ENA, {25'h0, 3'h7, 1'b0, r[2:0]});
      wait_en(r[2:0], 20);
    end
    uv <= 3'h7;
    ov <= 3'h7;
    buv <= 2'h3;
    en_x = ch_en_o;
    repeat (2000) @(posedge clk_i);
    chk("manual hold", en_x, ch_en_o);
    uv <= 3'h0;
    ov <= 3'h0;
    buv <= 2'h0;
    wb(1, ADDR_ENA, 32'h0000_0070);
    wait_en(3'h0, 20);
    wb(1, ADDR_CFG, 32'h0000_0800);
    wb(1, ADDR_POS, 32'h0000_0FE9);
    wb(1, ADDR_ENA, 32'h0000_0077);
    wb(1, ADDR_CTRL, 32'h0000_0001);
    wait_en(3'h1, 200);
    chk("soft start", 3'h7, ss);
    wait_en(3'h7, 45000);
    chk("up gap", 1'b1, t >= d - TICK_CYC && t <= d + TICK_CYC + 200);
    wb(1, ADDR_CTRL, 32'h0000_0002);
    wait_en(3'h1, 20);
    chk("hard off", 3'h0, ss);
    wb(1, ADDR_ENA, 32'h0000_0070);
    wait_en(3'h0, 45000);
    chk("down gap", 1'b1, t >= d - TICK_CYC && t <= d + TICK_CYC + 200);
    wb(0, ADDR_STAT, 0);
    chk("stat", {3'(ST_DN_WAIT), 3'h0, 1'b0, 2'd1}, q[8:0]);
    // Force cuts the ramp of the first position, which holds every channel
    wb(1, ADDR_CTRL, 32'h0000_0004);
    wb(1, ADDR_POS, 32'h0000_0FC0);
    r = ($random(seed) & 32'h0000_0007) | 32'h0000_0070;
    if (r[2:0] == 3'h0) r = 32'h0000_0076;
    wb(1, ADDR_ENA, r);
    wb(1, ADDR_CTRL, 32'h0000_0001);
    wait_en(r[2:0], 500);
    wb(1, ADDR_CTRL, 32'h0000_0004);
    wait_en(3'h0, 8);
    wb(1, ADDR_ENA, 32'h0000_0077);
    // Undebounced pin edge starts the sequence
    wb(1, ADDR_CFG, 32'h0000_0982);
    pin <= 1'b1;
    wait_en(3'h7, 500);
    uv <= 3'h1;
    wait_en(3'h0, 1400);
    uv <= 3'h0;
    test_done();
  end
endmodule // tps_sequencer_tb
